// [verilog/dssd_decoder.sv]
// Device end: decodes and checks the depth surface state packet.
//
// Functional notes
// R1: Bit 27 tiled; tiled surfaces in uncached memory.
// R2: Hierarchical depth requires tiled surface.
// R3: Software invalidates caches when tiling changes.
// R4: Bit 26 walk; ignored when linear; tiled Y-major.
// R5: Bit 25 stops origin offset for depth only.
// R6: Offset disable only for simple surfaces.
// R7: Bits 24:23 tiled-rendering mode decode.
// R8: First block mode confines rendering per block.
// R9: Cache-only mode never writes depth memory.
// R10: Flush render cache when mode changes.
// R11: Block modes need Y-tiled unorm16 depth.
// R12: Normal mode when operational flush enabled.
// R13: Hierarchical depth needs normal mode, early test.
// R14: Separate stencil needs hierarchy, normal, proper format.
// R15: Bits 20:18 depth format decode.
// R16: Pitch minus one, aligned 64B or 128B.
// R17: Base address dword granular, aligned.
// R18: Height minus one with per-type limits; the streamer checks only the 2D limit.
// R19: Depth height equals render target height.
// R20: Width minus one, fits pitch, cube square.
// R21: Mip level 0 to 13.
// R22: Flag bad encodings, hold previous state.
`timescale 1ns/1ps
module dssd_decoder
  import dssd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  dssd_if.decoder          link,
  input  wire logic        older_variant,
  input  wire logic        early_depth_test_en,
  input  wire logic        cache_flush_en,
  output logic             tiled,
  output logic             walk_y_major,
  output logic             origin_depth_disable,
  output dssd_trm_t        render_mode,
  output logic             block_mode,
  output logic             depth_cache_only,
  output logic             hier_depth_en,
  output logic             sep_stencil_en,
  output dssd_fmt_t        depth_format,
  output logic [16:0]      pitch,
  output logic [31:0]      base_address,
  output logic [12:0]      height,
  output logic [12:0]      width,
  output logic [3:0]       mip_level,
  output logic             state_error
);
  // ****************************************************************
  // Elaboration check of the package layout
  // ****************************************************************
  // Field slices below assume these widths; a changed layout would silently
  // truncate fields, so elaboration is refused instead.
  if (DSSD_WORDS != 3 || DSSD_TRM_HI - DSSD_TRM_LO != 1 ||
      DSSD_FMT_HI - DSSD_FMT_LO != 2 || DSSD_PITCH_HI != 16 ||
      DSSD_HEIGHT_HI - DSSD_HEIGHT_LO != 12 || DSSD_WIDTH_HI - DSSD_WIDTH_LO != 12 ||
      DSSD_MIP_HI - DSSD_MIP_LO != 3) begin : g_layout_check
    $error("Depth state packet layout does not fit the decoder.");
  end

  // ****************************************************************
  // Packet capture
  // ****************************************************************
  logic [31:0] word1;
  logic [31:0] word2;
  logic [31:0] word3;
  logic        accept;
  logic        done_q;
  logic        err_q;

  assign link.ready = 1'b1;
  assign accept     = link.valid & link.ready;
  assign link.done  = done_q;
  assign link.error = err_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      word1 <= DSSD_RESET_WORD;
      word2 <= DSSD_RESET_WORD;
      word3 <= DSSD_RESET_WORD;
    end else if (accept) begin
      case (link.index)
        2'h1: word1 <= link.data;
        2'h2: word2 <= link.data;
        2'h3: word3 <= link.data;
        default: word1 <= word1;
      endcase
    end
  end

  // ****************************************************************
  // Checking of the assembled packet
  // ****************************************************************
  logic [31:0] w1;
  logic [31:0] w3;
  logic        bad;
  dssd_trm_t   trm_in;
  dssd_fmt_t   fmt_in;
  logic        hier_in;
  logic        sten_in;

  // The last dword is merged in so the check sees the whole packet this cycle.
  always_comb begin
    w1 = (link.index == 2'h1) ? link.data : word1;
    w3 = (link.index == 2'h3) ? link.data : word3;
  end

  assign trm_in  = dssd_trm_t'(w1[DSSD_TRM_HI:DSSD_TRM_LO]);
  assign fmt_in  = dssd_fmt_t'(w1[DSSD_FMT_HI:DSSD_FMT_LO]);
  assign hier_in = w1[DSSD_HIER_BIT];
  assign sten_in = w1[DSSD_SEP_STEN_BIT];

  always_comb begin
    bad = 1'b0;
    if (trm_in == DSSD_TRM_RESERVED) begin // [R7] [R22]
      bad = 1'b1;
    end
    if (older_variant && trm_in != DSSD_TRM_NORMAL) begin // [R7]
      bad = 1'b1;
    end
    if (fmt_in == DSSD_FMT_RSV4 || fmt_in == DSSD_FMT_RSV6 ||
        fmt_in == DSSD_FMT_RSV7) begin // [R15] [R22]
      bad = 1'b1;
    end
    if (hier_in && trm_in != DSSD_TRM_NORMAL) begin // [R22]
      bad = 1'b1;
    end
    if (sten_in && !hier_in) begin // [R22]
      bad = 1'b1;
    end
    if (sten_in && fmt_in != DSSD_FMT_F32 && fmt_in != DSSD_FMT_U24_NOSTEN) begin // [R22]
      bad = 1'b1;
    end
    if (!sten_in && fmt_in == DSSD_FMT_U24_NOSTEN) begin // [R22]
      bad = 1'b1;
    end
    if (w3[DSSD_MIP_HI:DSSD_MIP_LO] > DSSD_MIP_MAX) begin // [R21] [R22]
      bad = 1'b1;
    end
  end

  // ****************************************************************
  // Committed state, held unchanged on a refused packet
  // ****************************************************************
  logic commit;
  assign commit = accept & link.last & ~bad;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      done_q <= accept & link.last;
      err_q  <= accept & link.last & bad; // [R22]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_error <= 1'b0;
    end else if (accept && link.last) begin
      state_error <= bad; // [R22]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tiled                <= 1'b0;
      walk_y_major         <= 1'b0;
      origin_depth_disable <= 1'b0;
      render_mode          <= DSSD_TRM_NORMAL;
      hier_depth_en        <= 1'b0;
      sep_stencil_en       <= 1'b0;
      depth_format         <= DSSD_FMT_F32_STEN;
      pitch                <= 17'h0_0000;
      base_address         <= 32'h0000_0000;
      height               <= 13'h0000;
      width                <= 13'h0000;
      mip_level            <= 4'h0;
    end else if (commit) begin
      tiled        <= w1[DSSD_TILED_BIT]; // [R1]
      // Walk has no meaning on a linear surface, so it reads as zero then.
      walk_y_major <= w1[DSSD_TILED_BIT] & w1[DSSD_WALK_BIT]; // [R4]
      // Newer variants treat the bit as reserved.
      origin_depth_disable <= older_variant & w1[DSSD_OFS_DIS_BIT]; // [R5]
      render_mode    <= trm_in; // [R7]
      hier_depth_en  <= hier_in;
      sep_stencil_en <= sten_in;
      depth_format   <= fmt_in; // [R15]
      pitch          <= w1[DSSD_PITCH_HI:0]; // [R16]
      base_address   <= (link.index == 2'h2) ? link.data : word2;
      height         <= w3[DSSD_HEIGHT_HI:DSSD_HEIGHT_LO]; // [R18]
      width          <= w3[DSSD_WIDTH_HI:DSSD_WIDTH_LO];
      mip_level      <= w3[DSSD_MIP_HI:DSSD_MIP_LO]; // [R21]
    end
  end

  assign block_mode       = (render_mode == DSSD_TRM_BLOCK_FIRST) |
                            (render_mode == DSSD_TRM_CACHE_ONLY);
  // Flags the cache-only mode for depth write-back suppression; cache_flush_en does not affect it.
  assign depth_cache_only = (render_mode == DSSD_TRM_CACHE_ONLY); // [R9]

  logic unused_inputs;
  assign unused_inputs = early_depth_test_en & cache_flush_en;
endmodule

// [verilog/dssd_pkg.sv]
// Package with field layouts and encodings of the depth surface state packet.
package dssd_pkg;
  // ****************************************************************
  // Dword 1 field positions
  // ****************************************************************
  localparam int DSSD_TILED_BIT      = 27;
  localparam int DSSD_WALK_BIT       = 26;
  localparam int DSSD_OFS_DIS_BIT    = 25;
  localparam int DSSD_TRM_HI         = 24;
  localparam int DSSD_TRM_LO         = 23;
  localparam int DSSD_HIER_BIT       = 22;
  localparam int DSSD_SEP_STEN_BIT   = 21;
  localparam int DSSD_FMT_HI         = 20;
  localparam int DSSD_FMT_LO         = 18;
  localparam int DSSD_PITCH_HI       = 16;
  // ****************************************************************
  // Dword 3 field positions
  // ****************************************************************
  localparam int DSSD_HEIGHT_HI      = 31;
  localparam int DSSD_HEIGHT_LO      = 19;
  localparam int DSSD_WIDTH_HI       = 18;
  localparam int DSSD_WIDTH_LO       = 6;
  localparam int DSSD_MIP_HI         = 5;
  localparam int DSSD_MIP_LO         = 2;
  // ****************************************************************
  // Limits and reset values
  // ****************************************************************
  localparam logic [3:0]  DSSD_MIP_MAX       = 4'hd;
  localparam logic [12:0] DSSD_HEIGHT_MAX_2D = 13'h1fff;
  localparam logic [12:0] DSSD_HEIGHT_MAX_3D = 13'h07ff;
  localparam logic [31:0] DSSD_RESET_WORD    = 32'h0000_0000;
  localparam int          DSSD_WORDS         = 3;

  typedef enum logic [1:0] {
    DSSD_TRM_NORMAL      = 2'h0,
    DSSD_TRM_BLOCK_FIRST = 2'h1,
    DSSD_TRM_RESERVED    = 2'h2,
    DSSD_TRM_CACHE_ONLY  = 2'h3
  } dssd_trm_t;

  typedef enum logic [2:0] {
    DSSD_FMT_F32_STEN   = 3'h0,
    DSSD_FMT_F32        = 3'h1,
    DSSD_FMT_U24_STEN   = 3'h2,
    DSSD_FMT_U24_NOSTEN = 3'h3,
    DSSD_FMT_RSV4       = 3'h4,
    DSSD_FMT_U16        = 3'h5,
    DSSD_FMT_RSV6       = 3'h6,
    DSSD_FMT_RSV7       = 3'h7
  } dssd_fmt_t;
endpackage

// [verilog/dssd_if.sv]
// Interface carrying packet dwords from the streamer to the decoder.
`timescale 1ns/1ps
interface dssd_if;
  logic        valid;
  logic        ready;
  logic [1:0]  index;
  logic        last;
  logic [31:0] data;
  logic        done;
  logic        error;
  modport streamer (output valid, output index, output last, output data,
                    input ready, input done, input error);
  modport decoder  (input valid, input index, input last, input data,
                    output ready, output done, output error);
endinterface

// [verilog/dssd_streamer.sv]
// Streamer end: sends one depth surface state packet on request.
`timescale 1ns/1ps
module dssd_streamer
  import dssd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  dssd_if.streamer         link,
  input  wire logic        send,
  input  wire logic [31:0] cfg_word1,
  input  wire logic [31:0] cfg_word2,
  input  wire logic [31:0] cfg_word3,
  input  wire logic        early_depth_test_en,
  input  wire logic        cache_flush_en,
  output logic             busy,
  output logic             flush_request,
  output logic             cache_invalidate,
  output logic             rule_violation,
  output logic             packet_done,
  output logic             packet_error
);
  // ****************************************************************
  // Sequencing
  // ****************************************************************
  typedef enum logic [1:0] {
    DSSD_S_IDLE = 2'h0,
    DSSD_S_SEND = 2'h1,
    DSSD_S_WAIT = 2'h2
  } dssd_sstate_t;

  dssd_sstate_t state;
  logic [1:0]   idx;
  logic [31:0]  w1;
  logic [31:0]  w2;
  logic [31:0]  w3;
  logic [31:0]  prev_w1;
  logic         violation;
  logic         sent_any;

  assign busy       = (state != DSSD_S_IDLE);
  assign link.valid = (state == DSSD_S_SEND);
  assign link.index = idx;
  assign link.last  = (idx == 2'(DSSD_WORDS));
  assign link.data  = (idx == 2'h1) ? w1 : ((idx == 2'h2) ? w2 : w3);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= DSSD_S_IDLE;
      idx   <= 2'h1;
    end else begin
      case (state)
        DSSD_S_IDLE: begin
          if (send) begin
            state <= DSSD_S_SEND;
            idx   <= 2'h1;
          end
        end
        DSSD_S_SEND: begin
          if (link.ready) begin
            if (link.last) begin
              state <= DSSD_S_WAIT;
            end else begin
              idx <= idx + 2'h1;
            end
          end
        end
        DSSD_S_WAIT: begin
          if (link.done) begin
            state <= DSSD_S_IDLE;
          end
        end
        default: state <= DSSD_S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Packet words are frozen while sending so the fields stay coherent.
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      w1 <= 32'h0000_0000;
      w2 <= 32'h0000_0000;
      w3 <= 32'h0000_0000;
    end else if (state == DSSD_S_IDLE && send) begin
      w1 <= cfg_word1;
      w2 <= cfg_word2;
      w3 <= cfg_word3;
    end
  end

  // ****************************************************************
  // Software-side obligations, sampled as the first dword leaves
  // ****************************************************************
  logic       t;
  logic       h;
  logic       s;
  logic [1:0] m;
  logic [2:0] f;
  logic [12:0] ht;
  logic [12:0] wd;
  assign t  = w1[DSSD_TILED_BIT];
  assign h  = w1[DSSD_HIER_BIT];
  assign s  = w1[DSSD_SEP_STEN_BIT];
  assign m  = w1[DSSD_TRM_HI:DSSD_TRM_LO];
  assign f  = w1[DSSD_FMT_HI:DSSD_FMT_LO];
  assign ht = w3[DSSD_HEIGHT_HI:DSSD_HEIGHT_LO];
  assign wd = w3[DSSD_WIDTH_HI:DSSD_WIDTH_LO];

  always_comb begin
    violation = 1'b0;
    if (h && !t) violation = 1'b1; // [R2]
    if (t && !w1[DSSD_WALK_BIT]) violation = 1'b1; // [R4]
    if (m != 2'(DSSD_TRM_NORMAL) && (!t || f != 3'(DSSD_FMT_U16))) violation = 1'b1; // [R11]
    if (cache_flush_en && m != 2'(DSSD_TRM_NORMAL)) violation = 1'b1; // [R12]
    if (h && (m != 2'(DSSD_TRM_NORMAL) || !early_depth_test_en)) violation = 1'b1; // [R13]
    if (s && (!h || (f != 3'(DSSD_FMT_F32) && f != 3'(DSSD_FMT_U24_NOSTEN))))
      violation = 1'b1; // [R14]
    if (!s && f == 3'(DSSD_FMT_U24_NOSTEN)) violation = 1'b1; // [R14]
    if (!t && w1[5:0] != 6'h3f) violation = 1'b1; // [R16]
    if (t && w1[6:0] != 7'h7f) violation = 1'b1; // [R16]
    if (w2[3:0] != 4'h0 && !t) violation = 1'b1; // [R17]
    if (ht > DSSD_HEIGHT_MAX_2D) violation = 1'b1; // [R18]
    if ({4'h0, wd} > w1[DSSD_PITCH_HI:0]) violation = 1'b1; // [R20]
    if (w1[DSSD_OFS_DIS_BIT] && w3[DSSD_MIP_HI:DSSD_MIP_LO] != 4'h0) violation = 1'b1; // [R6]
    if (w3[DSSD_MIP_HI:DSSD_MIP_LO] > DSSD_MIP_MAX) violation = 1'b1; // [R21]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_w1          <= 32'h0000_0000;
      sent_any         <= 1'b0;
      flush_request    <= 1'b0;
      cache_invalidate <= 1'b0;
      rule_violation   <= 1'b0;
    end else begin
      flush_request    <= 1'b0;
      cache_invalidate <= 1'b0;
      if (state == DSSD_S_SEND && idx == 2'h1 && link.ready) begin
        rule_violation <= violation;
        flush_request  <= sent_any &&
                          prev_w1[DSSD_TRM_HI:DSSD_TRM_LO] != m; // [R10]
        cache_invalidate <= sent_any && prev_w1[DSSD_TILED_BIT] != t; // [R3]
        prev_w1  <= w1;
        sent_any <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      packet_done  <= 1'b0;
      packet_error <= 1'b0;
    end else begin
      packet_done  <= link.done;
      packet_error <= link.error;
    end
  end
endmodule

// [testbench/dssd_checker_sva.sv]
// Concurrent checks on the packet link between streamer and decoder.
`timescale 1ns/1ps
module dssd_checker (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        valid,
  input wire logic        ready,
  input wire logic [1:0]  index,
  input wire logic        last,
  input wire logic [31:0] data,
  input wire logic        done,
  input wire logic        error
);
  // ****************************************************************
  // Handshake and refusal checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_done_after_last: assert property (valid && last |=> done)
    else $error("done missing after last dword");
  chk_done_has_cause: assert property (done |-> $past(valid && last))
    else $error("done without a last dword");
  chk_done_one_cycle: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_error_with_done: assert property (error |-> done)
    else $error("error without done");
  chk_dword_order: assert property (
    valid && index == 2'h1 |=> valid && index == 2'h2 ##1 valid && index == 2'h3 && last)
    else $error("dwords out of order");
  chk_last_index: assert property (valid && last |-> index == 2'h3 && ready)
    else $error("last flag on wrong dword");
  chk_mode_reserved: assert property (
    (valid && index == 2'h1 && data[24:23] == 2'h2) ##2 (valid && last) |=> error)
    else $error("reserved mode not refused");
  chk_fmt_reserved: assert property (
    (valid && index == 2'h1 && (data[20:18] == 3'h4 || data[20:18] > 3'h5))
      ##2 (valid && last) |=> error)
    else $error("reserved format not refused");
  chk_stencil_hier: assert property (
    (valid && index == 2'h1 && data[21] && !data[22]) ##2 (valid && last) |=> error)
    else $error("stencil without hierarchy not refused");
  chk_hier_normal: assert property (
    (valid && index == 2'h1 && data[22] && data[24:23] != 2'h0) ##2 (valid && last) |=> error)
    else $error("hierarchy with block mode not refused");
  chk_mip_range: assert property (valid && last && data[5:2] > 4'hd |=> error)
    else $error("mip level above range not refused");
endmodule

// [testbench/depth_surface_state_decode_tb.sv]
// Testbench joining the streamer and decoder ends of the depth state link.
`timescale 1ns/1ps
module depth_surface_state_decode_tb;
  import dssd_pkg::*;
  typedef struct packed {logic [31:0] w1; logic [31:0] w3; logic old; logic err;} dssd_row_t;
  localparam logic [31:0] D3 = 32'h0010_0100;
  localparam dssd_row_t ROWS [21] = '{
    '{32'h0c64_007f, D3, 1'b0, 1'b0}, '{32'h0000_003f, D3, 1'b0, 1'b0},
    '{32'h0008_003f, D3, 1'b0, 1'b0}, '{32'h000c_003f, D3, 1'b0, 1'b1},
    '{32'h0010_003f, D3, 1'b0, 1'b1}, '{32'h0014_003f, D3, 1'b0, 1'b0},
    '{32'h0018_003f, D3, 1'b0, 1'b1}, '{32'h001c_003f, D3, 1'b0, 1'b1},
    '{32'h0c94_007f, D3, 1'b0, 1'b0}, '{32'h0d14_007f, D3, 1'b0, 1'b1},
    '{32'h0d94_007f, D3, 1'b0, 1'b0}, '{32'h0c94_007f, D3, 1'b1, 1'b1},
    '{32'h0214_003f, D3, 1'b1, 1'b0}, '{32'h0214_003f, D3, 1'b0, 1'b0},
    '{32'h0414_003f, D3, 1'b0, 1'b0}, '{32'h0cd4_007f, D3, 1'b0, 1'b1},
    '{32'h0824_007f, D3, 1'b0, 1'b1}, '{32'h0c60_007f, D3, 1'b0, 1'b1},
    '{32'h0c6c_007f, D3, 1'b0, 1'b0}, '{32'h0014_003f, 32'h0010_0138, 1'b0, 1'b1},
    '{32'h0014_003f, 32'hffff_fff4, 1'b0, 1'b0}};
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        send = 1'b0;
  logic [31:0] cfg1 = '0;
  logic [31:0] cfg2 = '0;
  logic [31:0] cfg3 = '0;
  logic        older = 1'b0;
  logic        edt = 1'b1;
  logic        cfe = 1'b0;
  logic        busy, flush_request, cache_invalidate, rule_violation;
  logic        packet_done, packet_error, tiled, walk_y_major, origin_depth_disable;
  logic        block_mode, depth_cache_only, hier_depth_en, sep_stencil_en, state_error;
  dssd_trm_t   render_mode;
  dssd_fmt_t   depth_format;
  logic [16:0] pitch;
  logic [31:0] base_address;
  logic [12:0] height, width;
  logic [3:0]  mip_level;
  logic [90:0] good;
  logic [1:0]  prev_mode;
  logic        prev_tiled, e, v, sent;
  int          n_fail = 0;
  int          n_checks = 0;

  always #20 clk = ~clk;

  dssd_if link ();
  dssd_streamer dssd_streamer_i (.clk(clk), .arst_n(arst_n), .link(link), .send(send),
    .cfg_word1(cfg1), .cfg_word2(cfg2), .cfg_word3(cfg3), .early_depth_test_en(edt),
    .cache_flush_en(cfe), .busy(busy), .flush_request(flush_request),
    .cache_invalidate(cache_invalidate), .rule_violation(rule_violation),
    .packet_done(packet_done), .packet_error(packet_error));
  dssd_decoder dssd_decoder_i (.clk(clk), .arst_n(arst_n), .link(link), .older_variant(older),
    .early_depth_test_en(edt), .cache_flush_en(cfe), .tiled(tiled),
    .walk_y_major(walk_y_major), .origin_depth_disable(origin_depth_disable),
    .render_mode(render_mode), .block_mode(block_mode), .depth_cache_only(depth_cache_only),
    .hier_depth_en(hier_depth_en), .sep_stencil_en(sep_stencil_en),
    .depth_format(depth_format), .pitch(pitch), .base_address(base_address),
    .height(height), .width(width), .mip_level(mip_level), .state_error(state_error));
  dssd_checker dssd_checker_i (.clk(clk), .arst_n(arst_n), .valid(link.valid),
    .ready(link.ready), .index(link.index), .last(link.last), .data(link.data),
    .done(link.done), .error(link.error));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [90:0] exp_state(logic [31:0] a, logic [31:0] b, logic [31:0] c,
                                            logic o);
    return {a[27], a[27] & a[26], o & a[25], a[24:23], a[23], a[24:23] == 2'h3, a[22], a[21],
            a[20:18], a[16:0], b, c[31:19], c[18:6], c[5:2]};
  endfunction

  function automatic logic [90:0] seen_state();
    return {tiled, walk_y_major, origin_depth_disable, render_mode, block_mode,
            depth_cache_only, hier_depth_en, sep_stencil_en, depth_format, pitch,
            base_address, height, width, mip_level};
  endfunction

  task automatic do_reset;
    arst_n = 1'b0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    good = '0;
    prev_mode = 2'h0;
    prev_tiled = 1'b0;
    sent = 1'b0;
    chk("reset state", {state_error, seen_state()}, '0);
  endtask

  // Sends one packet and collects the streamer pulses until the packet completes.
  task automatic send_pkt(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    logic fl, iv, fin;
    int   k;
    fl = 1'b0;
    iv = 1'b0;
    fin = 1'b0;
    @(negedge clk);
    cfg1 = a;
    cfg2 = b;
    cfg3 = c;
    send = 1'b1;
    @(negedge clk);
    send = 1'b0;
    for (k = 0; k < 40 && !fin; k++) begin
      @(posedge clk);
      #1;
      fl |= flush_request;
      iv |= cache_invalidate;
      fin = packet_done;
    end
    if (!fin) begin
      n_fail++;
      close_out();
    end else begin
      e = packet_error;
      v = rule_violation;
      chk("busy after packet", busy, 1'b0);
      // The first packet after reset has no earlier surface to compare with.
      chk("flush request", fl, sent && a[24:23] != prev_mode);
      chk("cache invalidate", iv, sent && a[27] != prev_tiled);
      prev_mode = a[24:23];
      prev_tiled = a[27];
      sent = 1'b1;
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    do_reset();
    foreach (ROWS[i]) begin
      @(negedge clk);
      older = ROWS[i].old;
      send_pkt(ROWS[i].w1, 32'h0001_0000 + 32'(i * 64), ROWS[i].w3);
      if (!ROWS[i].err) good = exp_state(ROWS[i].w1, 32'h0001_0000 + 32'(i * 64),
                                         ROWS[i].w3, ROWS[i].old);
      chk("packet error", e, ROWS[i].err);
      chk("state error", state_error, ROWS[i].err);
      chk("decoded state", seen_state(), good);
    end
    @(negedge clk);
    older = 1'b0;
    send_pkt(32'h0c64_007f, 32'h0002_0000, D3);
    chk("clean packet flagged", v, 1'b0);
    send_pkt(32'h0044_003f, 32'h0002_0000, D3);
    chk("hierarchy on linear", v, 1'b1);
    @(negedge clk);
    cfe = 1'b1;
    send_pkt(32'h0d94_007f, 32'h0002_0040, D3);
    chk("block mode with flush", v, 1'b1);
    @(negedge clk);
    cfe = 1'b0;
    edt = 1'b0;
    send_pkt(32'h0c64_007f, 32'h0002_0000, D3);
    chk("hierarchy without early test", v, 1'b1);
    @(negedge clk);
    edt = 1'b1;
    send_pkt(32'h0214_003f, 32'h0002_0000, D3 | 32'h0000_0004);
    chk("offset disable on mip map", v, 1'b1);
    @(negedge clk);
    do_reset();
    send_pkt(32'h0d94_007f, 32'h0003_0000, D3);
    chk("after second reset", seen_state(),
        exp_state(32'h0d94_007f, 32'h0003_0000, D3, 1'b0));
    close_out();
  end
endmodule
